// ### bench/eep_ctl_model.sv
// two-wire bus controller model: drives scl and pulls sda low
`timescale 1ns/1ps
`default_nettype none
module eep_ctl_model (
	// clock
	input  wire logic clk,
	// bus
	input  wire logic sda,
	output logic      scl,
	output logic      pull
);
	// scl stands high and sda is released between frames
	initial begin
		scl  = 1'b1;
		pull = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask : tick

	// one clock: long low phase covers the target's answer delay
	task automatic bit_io(input logic b, output logic r);
		scl <= 1'b0;
		tick(2);
		pull <= ~b;
		tick(4);
		scl <= 1'b1;
		tick(1);
		r = sda;
		tick(1);
	endtask : bit_io

	// long low phase lets the target drop its ack before scl rises
	task automatic start();
		scl <= 1'b0;
		tick(4);
		pull <= 1'b0;
		tick(4);
		scl <= 1'b1;
		tick(4);
		pull <= 1'b1;
		tick(4);
	endtask : start

	task automatic stop();
		scl <= 1'b0;
		tick(4);
		pull <= 1'b1;
		tick(4);
		scl <= 1'b1;
		tick(4);
		pull <= 1'b0;
		tick(4);
	endtask : stop

	////////////////////////////////////////////////////////////////////////
	// msb first, ninth clock released for the target's ack
	task automatic send(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], r);
		end
		bit_io(1'b1, r);
		ack = ~r;
	endtask : send

	task automatic recv(input logic more, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, r);
			d[i] = r;
		end
		bit_io(~more, r);
	endtask : recv
endmodule : eep_ctl_model
`default_nettype wire

// ### bench/test_eep_target.sv
// self-checking bench: two targets of both sizes on one bus
`timescale 1ns/1ps
`default_nettype none
module test_eep_target;
	localparam int WR_SIM = 200;
	logic       clk;
	logic       rst_b;
	logic       scl;
	logic       pull;
	logic       sda;
	logic       oe2;
	logic       oe4;
	logic       out2;
	logic       out4;
	logic       sb2;
	logic       sb4;
	logic       busy2;
	logic       busy4;
	logic       wp;
	logic       low4;
	logic [2:0] straps2;
	logic [1:0] straps4;
	logic       a;
	logic [7:0] q [8];
	int         err_count;
	int         check_count;

	// pull-up: released wire reads high
	assign sda = ~(pull | oe2 | oe4);

	initial begin
		clk = 1'b0;
	end
	always #50 clk = ~clk;

	////////////////////////////////////////////////////////////////////////
	eep_target #(.is_4k(1'b0), .wr_cycles(WR_SIM)) i_dut (
		.clk(clk), .rst_b(rst_b), .scl(scl), .sda_in(sda), .sda_out(out2), .sda_oe(oe2),
		.strap_addr_bit_high(straps2[2]), .strap_addr_bit_mid(straps2[1]),
		.strap_addr_bit_low(straps2[0]), .wp_upper(wp), .standby(sb2), .busy(busy2));
	eep_target #(.is_4k(1'b1), .wr_cycles(WR_SIM)) i_dut_4k (
		.clk(clk), .rst_b(rst_b), .scl(scl), .sda_in(sda), .sda_out(out4), .sda_oe(oe4),
		.strap_addr_bit_high(straps4[1]), .strap_addr_bit_mid(straps4[0]),
		.strap_addr_bit_low(low4), .wp_upper(wp), .standby(sb4), .busy(busy4));
	eep_ctl_model i_ctl (.clk(clk), .sda(sda), .scl(scl), .pull(pull));

	////////////////////////////////////////////////////////////////////////
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : give_verdict

	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk_byte

	task automatic chk_flag(input logic got, input logic exp);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk_flag

	// both targets back in standby within the program time plus 40 clocks
	task automatic wait_done();
		int n;
		n = 0;
		while (busy2 !== 1'b0 || busy4 !== 1'b0 || sb2 !== 1'b1 || sb4 !== 1'b1) begin
			@(negedge clk);
			n++;
			if (n > WR_SIM + 40) begin
				err_count++;
				$display("CHECK FAILED at %0t: got %h expected %h", $time, n, WR_SIM);
				give_verdict();
			end
		end
	endtask : wait_done

	task automatic wr(input logic [7:0] dw, input logic [7:0] wa, input logic [7:0] base,
			input int n);
		i_ctl.start();
		i_ctl.send(dw, a);
		chk_flag(a, 1'b1);
		i_ctl.send(wa, a);
		chk_flag(a, 1'b1);
		for (int i = 0; i < n; i++) begin
			i_ctl.send(base + 8'(i), a);
			chk_flag(a, 1'b1);
		end
		i_ctl.stop();
	endtask : wr

	// dummy write of the word address, repeated start, then n bytes
	task automatic rd(input logic [7:0] dw, input logic [7:0] wa, input int n);
		i_ctl.start();
		i_ctl.send(dw, a);
		chk_flag(a, 1'b1);
		i_ctl.send(wa, a);
		chk_flag(a, 1'b1);
		i_ctl.start();
		i_ctl.send(dw | 8'h01, a);
		chk_flag(a, 1'b1);
		for (int i = 0; i < n; i++) begin
			i_ctl.recv(i < n - 1, q[i]);
		end
		i_ctl.stop();
	endtask : rd

	////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		chk_flag(sb2 & sb4, 1'b1);
		chk_flag(busy2 | busy4, 1'b0);
		chk_flag(oe2 | oe4 | out2 | out4, 1'b0);
		$display("test reset done");
	endtask : t_reset

	task automatic t_byte_write();
		wr(8'haa, 8'h10, 8'h5a, 1);
		i_ctl.tick(4);
		chk_flag(busy2, 1'b1);
		chk_flag(sb2, 1'b0);
		i_ctl.start();
		i_ctl.send(8'haa, a);
		chk_flag(a, 1'b0);
		i_ctl.stop();
		wait_done();
		rd(8'haa, 8'h10, 1);
		chk_byte(q[0], 8'h5a);
		$display("test byte_write done");
	endtask : t_byte_write

	task automatic t_page_wrap();
		wr(8'haa, 8'h06, 8'h20, 10);
		wait_done();
		rd(8'haa, 8'h00, 8);
		for (int i = 0; i < 6; i++) begin
			chk_byte(q[i], 8'h22 + 8'(i));
		end
		chk_byte(q[6], 8'h28);
		chk_byte(q[7], 8'h29);
		$display("test page_wrap done");
	endtask : t_page_wrap

	task automatic t_read_roll();
		wr(8'haa, 8'hff, 8'h77, 1);
		wait_done();
		rd(8'haa, 8'hff, 2);
		chk_byte(q[0], 8'h77);
		chk_byte(q[1], 8'h22);
		$display("test read_roll done");
	endtask : t_read_roll

	task automatic t_protect();
		wr(8'haa, 8'h80, 8'h33, 1);
		wait_done();
		wp = 1'b1;
		wr(8'haa, 8'h80, 8'h11, 1);
		i_ctl.tick(8);
		chk_flag(busy2, 1'b0);
		rd(8'haa, 8'h80, 1);
		chk_byte(q[0], 8'h33);
		wp = 1'b0;
		$display("test protect done");
	endtask : t_protect

	task automatic t_select();
		i_ctl.start();
		i_ctl.send(8'hae, a);
		chk_flag(a, 1'b0);
		i_ctl.stop();
		chk_flag(sb2 & sb4, 1'b1);
		straps2 = 3'h6;
		i_ctl.start();
		i_ctl.send(8'hac, a);
		chk_flag(a, 1'b1);
		i_ctl.stop();
		straps2 = 3'h5;
		low4 = 1'b0;
		wr(8'ha6, 8'h05, 8'h99, 1);
		wait_done();
		wr(8'ha4, 8'h05, 8'h66, 1);
		wait_done();
		low4 = 1'b1;
		rd(8'ha6, 8'h05, 1);
		chk_byte(q[0], 8'h99);
		rd(8'ha4, 8'h05, 1);
		chk_byte(q[0], 8'h66);
		$display("test select done");
	endtask : t_select

	task automatic t_sw_reset();
		logic r;
		i_ctl.start();
		i_ctl.send(8'hab, a);
		for (int i = 0; i < 3; i++) begin
			i_ctl.bit_io(1'b1, r);
		end
		i_ctl.start();
		for (int i = 0; i < 9; i++) begin
			i_ctl.bit_io(1'b1, r);
		end
		i_ctl.start();
		i_ctl.stop();
		i_ctl.tick(4);
		chk_flag(sb2, 1'b1);
		i_ctl.start();
		i_ctl.send(8'haa, a);
		chk_flag(a, 1'b1);
		i_ctl.stop();
		i_ctl.tick(8);
		chk_flag(busy2, 1'b0);
		$display("test sw_reset done");
	endtask : t_sw_reset

	////////////////////////////////////////////////////////////////////////
	initial begin
		err_count = 0;
		check_count = 0;
		rst_b = 1'b0;
		wp = 1'b0;
		low4 = 1'b1;
		straps2 = 3'h5;
		straps4 = 2'h1;
		repeat (8) @(negedge clk);
		rst_b = 1'b1;
		repeat (6) @(negedge clk);
		t_reset();
		t_byte_write();
		t_page_wrap();
		t_read_roll();
		t_protect();
		t_select();
		t_sw_reset();
		give_verdict();
	end
endmodule : test_eep_target
`default_nettype wire

// ### rtl/eep_line_filt.sv
// two-stage synchroniser plus glitch filter for scl and sda
`timescale 1ns/1ps
`default_nettype none
module eep_line_filt (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst_b,
	// lines
	input  wire logic [1:0] raw,
	output logic      [1:0] clean
);
	logic [1:0] s1_ff;
	logic [1:0] s2_ff;
	logic [1:0] s3_ff;

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			s1_ff <= eep_pkg::LINE_IDLE;
			s2_ff <= eep_pkg::LINE_IDLE;
			s3_ff <= eep_pkg::LINE_IDLE;
		end else begin
			s1_ff <= raw;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
		end
	end

	// a level is taken only after two equal synchronised samples
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			clean <= eep_pkg::LINE_IDLE;
		end else begin
			for (int i = 0; i < 2; i++) begin
				if (s2_ff[i] == s3_ff[i]) begin
					clean[i] <= s2_ff[i];
				end
			end
		end
	end
endmodule : eep_line_filt
`default_nettype wire

// ### rtl/eep_mem.sv
// byte array with registered read data
`timescale 1ns/1ps
`default_nettype none
module eep_mem (
	// clock
	input  wire logic clk,
	// array port
	eep_mem_if.store  port
);
	logic [7:0] cells [eep_pkg::MEM_DEPTH];

	always_ff @(posedge clk) begin
		if (port.we) begin
			cells[port.waddr] <= port.wdata;
		end
	end

	always_ff @(posedge clk) begin
		port.rdata <= cells[port.raddr];
	end
endmodule : eep_mem
`default_nettype wire

// ### rtl/eep_mem_if.sv
// array port bundle between the protocol engine and the storage array
`timescale 1ns/1ps
`default_nettype none
interface eep_mem_if;
	logic       we;
	logic [8:0] waddr;
	logic [7:0] wdata;
	logic [8:0] raddr;
	logic [7:0] rdata;

	modport ctl   (output we, output waddr, output wdata, output raddr, input rdata);
	modport store (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : eep_mem_if
`default_nettype wire

// ### rtl/eep_pkg.sv
// shared constants and types of the two-wire eeprom target
package eep_pkg;

	////////////////////////////////////////////////////////////////////////
	// array geometry
	localparam int          ADDR_W       = 9;
	localparam int          MEM_DEPTH    = 512;
	localparam int          PBUF_DEPTH   = 16;
	localparam logic [8:0]  PAGE_MASK_2K = 9'h007;
	localparam logic [8:0]  PAGE_MASK_4K = 9'h00f;
	localparam logic [8:0]  ADDR_MAX_2K  = 9'h0ff;
	localparam logic [8:0]  ADDR_MAX_4K  = 9'h1ff;
	localparam logic [8:0]  ADDR_RESET   = 9'h000;

	////////////////////////////////////////////////////////////////////////
	// device address word fields
	localparam logic [3:0]  DEV_CODE     = 4'ha;
	localparam int          DEV_CODE_LSB = 4;
	localparam int          DEV_A2_POS   = 3;
	localparam int          DEV_A1_POS   = 2;
	localparam int          DEV_A0_POS   = 1;
	localparam int          DEV_RW_POS   = 0;
	localparam logic [3:0]  BIT_LAST     = 4'h8;

	////////////////////////////////////////////////////////////////////////
	// timing
	localparam int          CLK_PERIOD_NS = 100;
	localparam int          T_WR_MS       = 5;
	localparam int          WR_CYCLES     = T_WR_MS * 1000000 / CLK_PERIOD_NS;
	localparam logic [1:0]  LINE_IDLE     = 2'h3;

	////////////////////////////////////////////////////////////////////////
	// protocol states
	typedef enum logic [3:0] {
		st_idle      = 4'h0,
		st_dev       = 4'h1,
		st_dev_ack   = 4'h2,
		st_waddr     = 4'h3,
		st_waddr_ack = 4'h4,
		st_wdata     = 4'h5,
		st_wdata_ack = 4'h6,
		st_rd        = 4'h7,
		st_rd_ack    = 4'h8
	} eep_state_type;

endpackage : eep_pkg

// ### rtl/eep_target.sv
// two-wire bus target front end of a small serial eeprom
`timescale 1ns/1ps
`default_nettype none
// Function
// - sample bits on scl rise, change driven sda after scl fall
// - sda is only pulled low or released, never driven high
// - small variant: three strap pins select the device, eight per bus
// - large variant: lowest strap pin ignored, four per bus
// - protect pin high blocks writes to upper array half
// - small variant: 32 pages of 8 bytes, 8-bit word address
// - large variant: 32 pages of 16 bytes, 9-bit word address
// - program cycle ends within 5 ms of the closing stop
// - sda change while scl high is start or stop, not data
// - sda fall with scl high is start, detected in any state
// - sda rise with scl high is stop, read then goes to standby
// - eight-bit words, device pulls sda low on ninth clock as ack
// - standby at power-up and after stop once programming finishes
// - start, nine clocks, start, stop leaves device idle
// - address word opens with fixed pattern one zero one zero
// - small variant: address bits three to one equal strap pins
// - large variant: two straps match, third position is page bit
// - address word lsb: one reads, zero writes
// - match is acknowledged, mismatch stays silent until next start
// - no address ack while programming, allowing ack polling
// - page write increments only the low page bits, wrapping
// - counter keeps last address plus one, read wraps whole array
// - read continues while controller acks, ends on nack and stop
module eep_target #(
	parameter bit          is_4k     = 1'b0,
	parameter int unsigned wr_cycles = eep_pkg::WR_CYCLES
) (
	// clock and reset
	input  wire logic clk,
	input  wire logic rst_b,
	// bus lines
	input  wire logic scl,
	input  wire logic sda_in,
	output logic      sda_out,
	output logic      sda_oe,
	// straps and protection
	input  wire logic strap_addr_bit_high,
	input  wire logic strap_addr_bit_mid,
	input  wire logic strap_addr_bit_low,
	input  wire logic wp_upper,
	// status
	output logic      standby,
	output logic      busy
);
	localparam logic [8:0] PMASK = is_4k ? eep_pkg::PAGE_MASK_4K : eep_pkg::PAGE_MASK_2K;
	localparam logic [8:0] AMAX  = is_4k ? eep_pkg::ADDR_MAX_4K : eep_pkg::ADDR_MAX_2K;

	eep_pkg::eep_state_type st_ff;
	logic [1:0]  line_clean;
	logic        scl_f;
	logic        sda_f;
	logic        scl_d_ff;
	logic        sda_d_ff;
	logic [3:0]  pin_s1_ff;
	logic [3:0]  pin_s2_ff;
	logic [3:0]  cnt_ff;
	logic [7:0]  rx_ff;
	logic [7:0]  dev_ff;
	logic        ack_in_ff;
	logic [7:0]  tx_ff;
	logic        oe_ff;
	logic [8:0]  addr_ff;
	logic [8:0]  page_ff;
	logic [15:0] pvalid_ff;
	logic [7:0]  pbuf_ff [eep_pkg::PBUF_DEPTH];
	logic        busy_ff;
	logic [31:0] wr_cnt_ff;
	logic        standby_ff;
	logic        scl_rise;
	logic        scl_fall;
	logic        start_ev;
	logic        stop_ev;
	logic        byte_end;
	logic        dev_hit;
	logic        waddr_done;
	logic        wdata_done;
	logic        rd_done;
	logic        rd_load;
	logic        commit_go;
	logic        commit_end;
	logic        wp_s;
	logic [3:0]  pidx;

	eep_mem_if mem ();

	////////////////////////////////////////////////////////////////////////
	// helpers

	function automatic logic dev_match(input logic [7:0] w, input logic [2:0] pins);
		logic code_ok;
		logic strap_ok;
		code_ok  = w[7:eep_pkg::DEV_CODE_LSB] == eep_pkg::DEV_CODE;
		strap_ok = (w[eep_pkg::DEV_A2_POS] == pins[2]) && (w[eep_pkg::DEV_A1_POS] == pins[1]);
		// the large part uses the third position as page bit
		return code_ok && strap_ok && (is_4k || (w[eep_pkg::DEV_A0_POS] == pins[0]));
	endfunction : dev_match

	function automatic logic is_upper(input logic [8:0] a);
		return is_4k ? a[8] : a[7];
	endfunction : is_upper

	function automatic logic [8:0] addr_next(input logic [8:0] a);
		return (a == AMAX) ? eep_pkg::ADDR_RESET : 9'(a + 9'h001);
	endfunction : addr_next

	function automatic logic [8:0] page_next(input logic [8:0] a);
		return (a & ~PMASK) | (9'(a + 9'h001) & PMASK);
	endfunction : page_next

	////////////////////////////////////////////////////////////////////////
	// line conditioning and events

	eep_line_filt u_filt (
		.clk   (clk),
		.rst_b (rst_b),
		.raw   ({sda_in, scl}),
		.clean (line_clean)
	);

	assign scl_f = line_clean[0];
	assign sda_f = line_clean[1];

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			scl_d_ff <= 1'b1;
			sda_d_ff <= 1'b1;
		end else begin
			scl_d_ff <= scl_f;
			sda_d_ff <= sda_f;
		end
	end

	// protect pin and straps are plain pins, two stages
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			pin_s1_ff <= 4'h0;
			pin_s2_ff <= 4'h0;
		end else begin
			pin_s1_ff <= {wp_upper, strap_addr_bit_high, strap_addr_bit_mid, strap_addr_bit_low};
			pin_s2_ff <= pin_s1_ff;
		end
	end

	assign wp_s     = pin_s2_ff[3];
	assign scl_rise = scl_f && !scl_d_ff;
	assign scl_fall = !scl_f && scl_d_ff;
	assign start_ev = scl_f && scl_d_ff && sda_d_ff && !sda_f;
	assign stop_ev  = scl_f && scl_d_ff && !sda_d_ff && sda_f;

	assign byte_end   = scl_fall && (cnt_ff == eep_pkg::BIT_LAST);
	assign dev_hit    = byte_end && (st_ff == eep_pkg::st_dev) && dev_match(rx_ff, pin_s2_ff[2:0])
		&& !busy_ff;
	assign waddr_done = byte_end && (st_ff == eep_pkg::st_waddr);
	assign wdata_done = byte_end && (st_ff == eep_pkg::st_wdata);
	assign rd_done    = byte_end && (st_ff == eep_pkg::st_rd);
	assign rd_load    = scl_fall && (((st_ff == eep_pkg::st_dev_ack) && dev_ff[eep_pkg::DEV_RW_POS])
		|| ((st_ff == eep_pkg::st_rd_ack) && ack_in_ff));

	////////////////////////////////////////////////////////////////////////
	// protocol sequencer

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			st_ff     <= eep_pkg::st_idle;
			cnt_ff    <= 4'h0;
			rx_ff     <= 8'h00;
			dev_ff    <= 8'h00;
			ack_in_ff <= 1'b0;
		end else if (start_ev) begin
			st_ff  <= eep_pkg::st_dev;
			cnt_ff <= 4'h0;
		end else if (stop_ev) begin
			st_ff <= eep_pkg::st_idle;
		end else begin
			if (scl_rise) begin
				rx_ff  <= {rx_ff[6:0], sda_f};
				cnt_ff <= 4'(cnt_ff + 4'h1);
				if (st_ff == eep_pkg::st_rd_ack) begin
					ack_in_ff <= !sda_f;
				end
			end
			if (scl_fall) begin
				case (st_ff)
				eep_pkg::st_dev: begin
					if (byte_end) begin
						dev_ff <= rx_ff;
						cnt_ff <= 4'h0;
						st_ff  <= dev_hit ? eep_pkg::st_dev_ack : eep_pkg::st_idle;
					end
				end
				eep_pkg::st_dev_ack: begin
					cnt_ff <= 4'h0;
					st_ff  <= dev_ff[eep_pkg::DEV_RW_POS] ? eep_pkg::st_rd : eep_pkg::st_waddr;
				end
				eep_pkg::st_waddr: begin
					if (byte_end) begin
						cnt_ff <= 4'h0;
						st_ff  <= eep_pkg::st_waddr_ack;
					end
				end
				eep_pkg::st_waddr_ack, eep_pkg::st_wdata_ack: begin
					cnt_ff <= 4'h0;
					st_ff  <= eep_pkg::st_wdata;
				end
				eep_pkg::st_wdata: begin
					if (byte_end) begin
						cnt_ff <= 4'h0;
						st_ff  <= eep_pkg::st_wdata_ack;
					end
				end
				eep_pkg::st_rd: begin
					if (byte_end) begin
						cnt_ff <= 4'h0;
						st_ff  <= eep_pkg::st_rd_ack;
					end
				end
				eep_pkg::st_rd_ack: begin
					cnt_ff <= 4'h0;
					st_ff  <= ack_in_ff ? eep_pkg::st_rd : eep_pkg::st_idle;
				end
				default: begin
					st_ff <= eep_pkg::st_idle;
				end
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// sda driver: open drain, changes only after an scl fall, a start or a stop

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			oe_ff <= 1'b0;
			tx_ff <= 8'h00;
		end else if (start_ev || stop_ev) begin
			oe_ff <= 1'b0;
		end else if (scl_fall) begin
			if (dev_hit || waddr_done || wdata_done) begin
				oe_ff <= 1'b1;
			end else if (rd_load) begin
				tx_ff <= mem.rdata;
				oe_ff <= !mem.rdata[7];
			end else if ((st_ff == eep_pkg::st_rd) && !byte_end) begin
				tx_ff <= {tx_ff[6:0], 1'b0};
				oe_ff <= !tx_ff[6];
			end else begin
				oe_ff <= 1'b0;
			end
		end
	end

	assign sda_out = 1'b0;
	assign sda_oe  = oe_ff;

	////////////////////////////////////////////////////////////////////////
	// word address counter

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			addr_ff <= eep_pkg::ADDR_RESET;
		end else if (waddr_done) begin
			addr_ff <= is_4k ? {dev_ff[eep_pkg::DEV_A0_POS], rx_ff} : {1'b0, rx_ff};
		end else if (wdata_done) begin
			addr_ff <= page_next(addr_ff);
		end else if (rd_done) begin
			addr_ff <= addr_next(addr_ff);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// page buffer, filled during the transfer, programmed after stop

	assign pidx = addr_ff[3:0] & PMASK[3:0];

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			pvalid_ff <= 16'h0000;
			page_ff   <= eep_pkg::ADDR_RESET;
		end else if (commit_end) begin
			pvalid_ff <= 16'h0000;
		end else if (start_ev && !busy_ff) begin
			pvalid_ff <= 16'h0000;
		end else if (wdata_done) begin
			page_ff <= addr_ff;
			if (!(wp_s && is_upper(addr_ff))) begin
				pvalid_ff[pidx] <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (wdata_done) begin
			pbuf_ff[pidx] <= rx_ff;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// program cycle

	assign commit_go  = stop_ev && !busy_ff && (|pvalid_ff) && ((st_ff == eep_pkg::st_wdata)
		|| (st_ff == eep_pkg::st_wdata_ack));
	assign commit_end = busy_ff && (wr_cnt_ff == 32'(wr_cycles - 1));

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			busy_ff   <= 1'b0;
			wr_cnt_ff <= 32'h0000_0000;
		end else if (commit_go) begin
			busy_ff   <= 1'b1;
			wr_cnt_ff <= 32'h0000_0000;
		end else if (busy_ff) begin
			wr_cnt_ff <= 32'(wr_cnt_ff + 32'h1);
			if (commit_end) begin
				busy_ff <= 1'b0;
			end
		end
	end

	// one buffered byte per clock during the first cycles of the program cycle
	assign mem.we    = busy_ff && (wr_cnt_ff < 32'(eep_pkg::PBUF_DEPTH))
		&& pvalid_ff[wr_cnt_ff[3:0]];
	assign mem.waddr = (page_ff & ~PMASK) | {5'h00, wr_cnt_ff[3:0]};
	assign mem.wdata = pbuf_ff[wr_cnt_ff[3:0]];
	assign mem.raddr = addr_ff;

	eep_mem u_mem (
		.clk  (clk),
		.port (mem.ctl)
	);

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			standby_ff <= 1'b1;
		end else begin
			standby_ff <= (st_ff == eep_pkg::st_idle) && !busy_ff;
		end
	end

	assign standby = standby_ff;
	assign busy    = busy_ff;

	////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);

	property p_drive_after_fall;
		$changed(oe_ff) |-> $past(scl_fall || start_ev || stop_ev);
	endproperty
	a_drive_after_fall: assert property (p_drive_after_fall) else $error("sda moved off fall");

	property p_start_any;
		start_ev |=> (st_ff == eep_pkg::st_dev) && (cnt_ff == 4'h0) && !oe_ff;
	endproperty
	a_start_any: assert property (p_start_any) else $error("start not taken");

	property p_stop_idle;
		stop_ev |=> (st_ff == eep_pkg::st_idle) ##1 (standby_ff == !$past(busy_ff));
	endproperty
	a_stop_idle: assert property (p_stop_idle) else $error("stop did not idle");

	property p_mismatch_silent;
		(byte_end && (st_ff == eep_pkg::st_dev) && !dev_hit) |=> !oe_ff && (st_ff == eep_pkg::st_idle);
	endproperty
	a_mismatch_silent: assert property (p_mismatch_silent) else $error("mismatch answered");

	property p_word_ack;
		(waddr_done || wdata_done || dev_hit) |=> oe_ff;
	endproperty
	a_word_ack: assert property (p_word_ack) else $error("ack not driven");

	// the ack stands through the whole ninth clock, up to the fall that ends it
	property p_ack_hold;
		((st_ff == eep_pkg::st_dev_ack) || (st_ff == eep_pkg::st_waddr_ack)
			|| (st_ff == eep_pkg::st_wdata_ack)) |-> oe_ff;
	endproperty
	a_ack_hold: assert property (p_ack_hold) else $error("ack not held");

	property p_poll_busy;
		busy_ff |-> (st_ff != eep_pkg::st_dev_ack);
	endproperty
	a_poll_busy: assert property (p_poll_busy) else $error("acked while busy");

	property p_wr_bound;
		busy_ff |-> (wr_cnt_ff < 32'(wr_cycles));
	endproperty
	a_wr_bound: assert property (p_wr_bound) else $error("program cycle too long");

	property p_page_wrap;
		wdata_done |=> ((addr_ff & ~PMASK) == ($past(addr_ff) & ~PMASK));
	endproperty
	a_page_wrap: assert property (p_page_wrap) else $error("page bits moved");

	property p_read_inc;
		rd_done |=> (addr_ff == addr_next($past(addr_ff)));
	endproperty
	a_read_inc: assert property (p_read_inc) else $error("read address step wrong");

	property p_protect;
		(wdata_done && wp_s && is_upper(addr_ff) && !pvalid_ff[pidx]) |=> !pvalid_ff[$past(pidx)];
	endproperty
	a_protect: assert property (p_protect) else $error("protected byte queued");

	c_write: cover property (commit_go ##1 busy_ff);
	c_read_seq: cover property (rd_load ##[1:200] rd_load);
	c_poll_nack: cover property (busy_ff && byte_end && (st_ff == eep_pkg::st_dev));
endmodule : eep_target
`default_nettype wire

// ### rtl/eep_target_end.sv
// empty unit: the target needs no further sources
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire
